// ### rtl/persist_timer.sv
// Qualifying timer: counts ticks while a condition holds uninterrupted
`default_nettype none
module persist_timer
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic tick,
  input wire logic cond,
  input wire logic [7:0] limit,
  output logic done
);
  logic [7:0] cnt_ff;
  // Restart from zero whenever the condition drops
  always_ff @(posedge clk_sys)
  begin
    if (reset || !cond)
      cnt_ff <= 8'h00; // [R15]
    else if (tick && cnt_ff != limit)
      cnt_ff <= cnt_ff + 8'h01;
  end
  assign done = cond && (cnt_ff == limit);
endmodule : persist_timer
`default_nettype wire

// ### rtl/thermal_pkg.sv
// Constants and types for the cabinet thermal supervision block
`default_nettype none
package thermal_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OFFSET = 8'h04;
  localparam logic [7:0] ADDR_FAN_ON = 8'h08;
  localparam logic [7:0] ADDR_OVERHEAT = 8'h0C;
  localparam logic [7:0] ADDR_DELAY = 8'h10;
  localparam logic [7:0] ADDR_COLD = 8'h14;
  localparam logic [7:0] ADDR_TEMP = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h24;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h28;
  // ----------------------------------------------------------------
  // Reset values and limits, degrees Celsius, signed 8 bit; delay in minutes, unsigned
  // ----------------------------------------------------------------
  localparam logic signed [7:0] OFFSET_RST = 8'sh00;
  localparam logic signed [7:0] OFFSET_MIN = -8'sd10;
  localparam logic signed [7:0] OFFSET_MAX = 8'sd10;
  localparam logic signed [7:0] FAN_ON_RST = 8'sd30;
  localparam logic signed [7:0] FAN_ON_MIN = 8'sd25;
  localparam logic signed [7:0] FAN_ON_MAX = 8'sd40;
  localparam logic signed [7:0] FAN_HYST = 8'sd5;
  localparam logic signed [7:0] OVERHEAT_RST = 8'sd48;
  localparam logic signed [7:0] OVERHEAT_MIN = 8'sd35;
  localparam logic signed [7:0] OVERHEAT_MAX = 8'sd65;
  localparam logic [7:0] DELAY_RST = 8'h0F;
  localparam logic [7:0] DELAY_MAX = 8'hF0;
  localparam logic signed [7:0] COLD_RST = -8'sd10;
  localparam logic signed [7:0] WARN_MARGIN = 8'sd3;
  localparam logic signed [7:0] CLEAR_HYST = 8'sd13;
  localparam logic signed [7:0] STOP_MARGIN = 8'sd15;
  localparam logic signed [7:0] RISE_LIMIT = 8'sd5;
  localparam logic signed [7:0] RISE_FLOOR = 8'sd35;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int SEC_TICK_CYC = CLK_HZ;
  localparam int WARN_DELAY_S = 3;
  localparam int KEY_HOLD_S = 3;
  localparam int SEC_PER_MIN = 60;
  // ----------------------------------------------------------------
  // Interrupt bits
  // ----------------------------------------------------------------
  localparam int IRQ_WARN = 0;
  localparam int IRQ_ALARM = 1;
  localparam int IRQ_STOP = 2;
  localparam int IRQ_FAN = 3;
  localparam int IRQ_W = 4;
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_ALARM = 3'b010,
    ST_STOP = 3'b100
  } therm_state_t;
endpackage : thermal_pkg
`default_nettype wire

// ### rtl/thermal_supervision_fan_alarm.sv
// Cabinet temperature supervision: fan, warning, alarm, stop
// Summary of operation
// [R1] Working temp is raw minus signed offset
// [R2] Working temp drives readout, fan, alarms
// [R3] Fan on at configurable threshold
// [R4] Fan off five degrees below threshold
// [R5] Excess threshold and minute delay held
// [R6] Warning seconds after excess minus three
// [R7] Excess held for delay: alarm, steps off
// [R8] Clear after 13 below for delay
// [R9] Power-up below warning starts cleared
// [R10] Excess plus 15: latched stop, fan off
// [R11] Rise over 5 per minute above 35: stop
// [R12] Long double key press restarts from stop
// [R13] Cold for delay raises same alarm
// [R14] Cold alarm clears after delay above threshold
// [R15] Timers restart when condition breaks
`default_nettype none
module thermal_supervision_fan_alarm
  import thermal_pkg::*;
#(
  parameter int SEC_CYC = thermal_pkg::SEC_TICK_CYC
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic sample_valid,
  input wire logic signed [7:0] raw_temp,
  input wire logic key_down_pin,
  input wire logic key_right_pin,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic fan_on,
  output logic steps_off,
  output logic advance_temperature_warning,
  output logic excess_temperature_alarm,
  output logic out_of_operation,
  output logic irq
);
  import thermal_pkg::*;
  // ----------------------------------------------------------------
  // Second and minute enables
  // ----------------------------------------------------------------
  logic [23:0] div_ff;
  logic sec_tick;
  logic [5:0] sec_cnt_ff;
  logic min_tick;
  always_ff @(posedge clk_sys)
  begin
    if (reset || div_ff == 24'(SEC_CYC - 1))
      div_ff <= 24'h000000;
    else
      div_ff <= div_ff + 24'h000001;
  end
  assign sec_tick = (div_ff == 24'(SEC_CYC - 1));
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      sec_cnt_ff <= 6'h00;
    else if (sec_tick)
      sec_cnt_ff <= (sec_cnt_ff == 6'(SEC_PER_MIN - 1)) ? 6'h00 : sec_cnt_ff + 6'h01;
  end
  assign min_tick = sec_tick && (sec_cnt_ff == 6'(SEC_PER_MIN - 1));
  // ----------------------------------------------------------------
  // Key synchronisers
  // ----------------------------------------------------------------
  logic [2:0] kd_ff;
  logic [2:0] kr_ff;
  logic keys_ff;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      kd_ff <= 3'h0;
      kr_ff <= 3'h0;
      keys_ff <= 1'b0;
    end
    else
    begin
      kd_ff <= {kd_ff[1:0], key_down_pin};
      kr_ff <= {kr_ff[1:0], key_right_pin};
      if (kd_ff[1] == kd_ff[2] && kr_ff[1] == kr_ff[2])
        keys_ff <= kd_ff[2] && kr_ff[2];
    end
  end
  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic signed [7:0] offset_ff;
  logic signed [7:0] fan_thr_ff;
  logic signed [7:0] over_thr_ff;
  logic [7:0] delay_ff;
  logic signed [7:0] cold_thr_ff;
  logic [IRQ_W-1:0] irq_en_ff;
  logic wr_en;
  logic signed [7:0] wv;
  assign wr_en = psel && penable && pwrite;
  assign wv = pwdata[7:0];
  // Writes outside the documented ranges are clamped
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      offset_ff <= OFFSET_RST;
      fan_thr_ff <= FAN_ON_RST;
      over_thr_ff <= OVERHEAT_RST;
      delay_ff <= DELAY_RST;
      cold_thr_ff <= COLD_RST;
      irq_en_ff <= '0;
    end
    else if (wr_en)
    begin
      case (paddr)
        ADDR_OFFSET: offset_ff <= (wv < OFFSET_MIN) ? OFFSET_MIN : (wv > OFFSET_MAX) ? OFFSET_MAX : wv; // [R1]
        ADDR_FAN_ON: fan_thr_ff <= (wv < FAN_ON_MIN) ? FAN_ON_MIN : (wv > FAN_ON_MAX) ? FAN_ON_MAX : wv; // [R3]
        ADDR_OVERHEAT: over_thr_ff <= (wv < OVERHEAT_MIN) ? OVERHEAT_MIN : (wv > OVERHEAT_MAX) ? OVERHEAT_MAX : wv; // [R5]
        ADDR_DELAY: delay_ff <= (pwdata[7:0] > DELAY_MAX) ? DELAY_MAX : pwdata[7:0]; // [R5]
        ADDR_COLD: cold_thr_ff <= wv;
        ADDR_IRQ_EN: irq_en_ff <= pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Working temperature and previous-minute sample
  // ----------------------------------------------------------------
  logic signed [7:0] temp_ff;
  logic temp_ok_ff;
  logic signed [7:0] last_min_ff;
  logic signed [8:0] diff;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      temp_ff <= 8'sh00;
      temp_ok_ff <= 1'b0;
    end
    else if (sample_valid)
    begin
      temp_ff <= 8'(raw_temp - offset_ff); // [R1]
      temp_ok_ff <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      last_min_ff <= 8'sh00;
    else if (!temp_ok_ff)
      last_min_ff <= 8'(raw_temp - offset_ff); // First sample seeds the reference, no false rise [R11]
    else if (min_tick)
      last_min_ff <= temp_ff;
  end
  // Sampled once a minute: a spike that subsides inside one minute is not seen
  assign diff = 9'(temp_ff) - 9'(last_min_ff);
  // ----------------------------------------------------------------
  // Threshold comparisons, 9 bit to avoid overflow
  // ----------------------------------------------------------------
  logic signed [8:0] t9;
  logic warn_c;
  logic hot_c;
  logic cool_c;
  logic cold_c;
  logic stop_c;
  logic rise_c;
  assign t9 = 9'(temp_ff);
  assign warn_c = temp_ok_ff && (t9 > 9'(over_thr_ff) - 9'(WARN_MARGIN)); // [R2] [R6]
  assign hot_c = temp_ok_ff && (t9 > 9'(over_thr_ff)); // [R7]
  assign cool_c = t9 <= 9'(over_thr_ff) - 9'(CLEAR_HYST); // [R8]
  assign cold_c = temp_ok_ff && (t9 < 9'(cold_thr_ff)); // [R13]
  assign stop_c = temp_ok_ff && (t9 >= 9'(over_thr_ff) + 9'(STOP_MARGIN)); // [R10]
  assign rise_c = min_tick && temp_ok_ff && (t9 > 9'(RISE_FLOOR)) && (diff > 9'(RISE_LIMIT)); // [R11]
  // ----------------------------------------------------------------
  // Qualifying timers
  // ----------------------------------------------------------------
  logic warn_done;
  logic hot_done;
  logic cool_done;
  logic cold_done;
  logic warm_done;
  logic key_done;
  logic cold_alarm_ff;
  persist_timer u_warn (.clk_sys(clk_sys), .reset(reset), .tick(sec_tick), .cond(warn_c),
    .limit(8'(WARN_DELAY_S)), .done(warn_done)); // [R6]
  persist_timer u_hot (.clk_sys(clk_sys), .reset(reset), .tick(min_tick), .cond(hot_c),
    .limit(delay_ff), .done(hot_done)); // [R7]
  persist_timer u_cool (.clk_sys(clk_sys), .reset(reset), .tick(min_tick), .cond(cool_c && !cold_c),
    .limit(delay_ff), .done(cool_done)); // [R8]
  persist_timer u_cold (.clk_sys(clk_sys), .reset(reset), .tick(min_tick), .cond(cold_c),
    .limit(delay_ff), .done(cold_done)); // [R13]
  persist_timer u_warm (.clk_sys(clk_sys), .reset(reset), .tick(min_tick), .cond(temp_ok_ff && !cold_c),
    .limit(delay_ff), .done(warm_done)); // [R14]
  persist_timer u_key (.clk_sys(clk_sys), .reset(reset), .tick(sec_tick), .cond(keys_ff),
    .limit(8'(KEY_HOLD_S)), .done(key_done)); // [R12]
  // ----------------------------------------------------------------
  // Alarm state machine
  // ----------------------------------------------------------------
  therm_state_t state_ff;
  // Reset is the power cycle: alarm and switch-off start cleared
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_ff <= ST_RUN; // [R9]
      cold_alarm_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_RUN:
        begin
          if (stop_c || rise_c)
            state_ff <= ST_STOP; // [R10] [R11]
          else if (hot_done || cold_done)
          begin
            state_ff <= ST_ALARM; // [R7] [R13]
            cold_alarm_ff <= cold_done && !hot_done;
          end
        end
        ST_ALARM:
        begin
          if (stop_c || rise_c)
            state_ff <= ST_STOP;
          else if (cold_alarm_ff ? warm_done : cool_done)
            state_ff <= ST_RUN; // [R8] [R14]
        end
        ST_STOP:
        begin
          if (key_done)
            state_ff <= ST_RUN; // [R12]
        end
        default: state_ff <= ST_RUN;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic nxt_fan;
  always_comb
  begin
    nxt_fan = fan_on;
    if (state_ff == ST_STOP)
      nxt_fan = 1'b0; // [R10] [R11]
    else if (temp_ok_ff && t9 >= 9'(fan_thr_ff))
      nxt_fan = 1'b1; // [R3]
    else if (t9 <= 9'(fan_thr_ff) - 9'(FAN_HYST))
      nxt_fan = 1'b0; // [R4]
  end
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      fan_on <= 1'b0;
      steps_off <= 1'b0;
      advance_temperature_warning <= 1'b0;
      excess_temperature_alarm <= 1'b0;
      out_of_operation <= 1'b0;
    end
    else
    begin
      fan_on <= nxt_fan;
      steps_off <= (state_ff != ST_RUN); // [R7]
      excess_temperature_alarm <= (state_ff == ST_ALARM);
      advance_temperature_warning <= warn_done && (state_ff == ST_RUN); // [R6] [R7]
      out_of_operation <= (state_ff == ST_STOP);
    end
  end
  // ----------------------------------------------------------------
  // Interrupts: set wins over clear
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  assign ev = {nxt_fan && !fan_on, state_ff == ST_STOP, state_ff == ST_ALARM, warn_done};
  assign clr = (wr_en && paddr == ADDR_IRQ_CLR) ? pwdata[IRQ_W-1:0] : '0;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      irq_stat_ff <= '0;
      irq <= 1'b0;
    end
    else
    begin
      irq_stat_ff <= (irq_stat_ff & ~clr) | ev;
      irq <= |(((irq_stat_ff & ~clr) | ev) & irq_en_ff);
    end
  end
  // ----------------------------------------------------------------
  // APB read side: no wait state, answer in first access cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable)
      begin
        case (paddr)
          ADDR_CTRL: prdata <= 32'h00000000;
          ADDR_OFFSET: prdata <= {24'h000000, offset_ff};
          ADDR_FAN_ON: prdata <= {24'h000000, fan_thr_ff};
          ADDR_OVERHEAT: prdata <= {24'h000000, over_thr_ff};
          ADDR_DELAY: prdata <= {24'h000000, delay_ff};
          ADDR_COLD: prdata <= {24'h000000, cold_thr_ff};
          ADDR_TEMP: prdata <= {24'h000000, temp_ff}; // [R2]
          ADDR_STATUS: prdata <= {27'h0000000, out_of_operation, excess_temperature_alarm,
            advance_temperature_warning, steps_off, fan_on};
          ADDR_IRQ_STAT: prdata <= {28'h0000000, irq_stat_ff};
          ADDR_IRQ_EN: prdata <= {28'h0000000, irq_en_ff};
          ADDR_IRQ_CLR: prdata <= 32'h00000000;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_STOP_FAN_OFF: assert property (@(posedge clk_sys) disable iff (reset) // [R10]
    state_ff == ST_STOP |=> !fan_on) else $error("fan on during stop");
  AST_STOP_ENTRY: assert property (@(posedge clk_sys) disable iff (reset) // [R10]
    (stop_c && state_ff != ST_STOP) |=> state_ff == ST_STOP) else $error("stop not entered");
  AST_ALARM_STEPS: assert property (@(posedge clk_sys) disable iff (reset) // [R7]
    state_ff == ST_ALARM |=> steps_off && excess_temperature_alarm) else $error("alarm without steps off");
  AST_FAN_ON: assert property (@(posedge clk_sys) disable iff (reset) // [R3]
    (state_ff != ST_STOP && temp_ok_ff && t9 >= 9'(fan_thr_ff)) |=> fan_on) else $error("fan not on");
  AST_FAN_HYST: assert property (@(posedge clk_sys) disable iff (reset) // [R4]
    ($fell(fan_on) && $past(state_ff) != ST_STOP) |-> $past(t9) <= 9'(fan_thr_ff) - 9'(FAN_HYST))
    else $error("fan off inside band");
  AST_NO_WARN_IN_ALARM: assert property (@(posedge clk_sys) disable iff (reset) // [R7]
    state_ff == ST_ALARM |=> !advance_temperature_warning) else $error("warning not replaced");
  AST_STOP_HOLD: assert property (@(posedge clk_sys) disable iff (reset) // [R12]
    (state_ff == ST_STOP && !key_done) |=> state_ff == ST_STOP) else $error("stop left without keys");
  AST_OFFSET_RANGE: assert property (@(posedge clk_sys) disable iff (reset) // [R1]
    offset_ff >= OFFSET_MIN && offset_ff <= OFFSET_MAX) else $error("offset out of range");
  AST_ALARM_CAUSE: assert property (@(posedge clk_sys) disable iff (reset) // [R7]
    ($past(state_ff) == ST_RUN && state_ff == ST_ALARM) |-> $past(hot_done || cold_done))
    else $error("alarm without qualified cause");
endmodule : thermal_supervision_fan_alarm
`default_nettype wire

// ### sim/tb.sv
// Testbench: thermal supervision scenarios over APB and the sensor model
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
`define WAITV(s, v, m) begin n = 0; while ((s) !== (v) && n < (m)) begin @(posedge clk_sys); n++; end end
module tb;
  import thermal_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic signed [7:0] cab_temp = 8'sd20;
  logic sample_valid;
  logic signed [7:0] raw_temp;
  logic key_down_pin = 1'b0;
  logic key_right_pin = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, fan_on, steps_off, warn, alarm, stop, irq;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  // ----------------------------------------------------------------
  // Clock, timeout, instances
  // ----------------------------------------------------------------
  always #50 clk_sys = ~clk_sys;
  // Ceiling well above the roughly 25k cycles the scenarios need
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  temp_sensor_model sensor (.clk_sys(clk_sys), .reset(reset), .cabinet_temp(cab_temp),
    .sample_valid(sample_valid), .raw_temp(raw_temp));
  thermal_supervision_fan_alarm #(.SEC_CYC(10)) DUT (.clk_sys(clk_sys), .reset(reset),
    .sample_valid(sample_valid), .raw_temp(raw_temp), .key_down_pin(key_down_pin),
    .key_right_pin(key_right_pin), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fan_on(fan_on), .steps_off(steps_off), .advance_temperature_warning(warn),
    .excess_temperature_alarm(alarm), .out_of_operation(stop), .irq(irq));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (k == 16)
      bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic settemp(input logic signed [7:0] t, input int k);
    cab_temp <= t;
    repeat (k) @(posedge clk_sys);
  endtask : settemp
  // Climb at most 4 degrees per minute so the fast-rise stop stays quiet
  task automatic ramp(input logic signed [7:0] t);
    int c;
    c = cab_temp;
    while (c != t)
    begin
      c = (t > c + 4) ? c + 4 : (t < c - 4) ? c - 4 : t;
      cab_temp <= 8'(c);
      repeat (600) @(posedge clk_sys);
    end
  endtask : ramp
  task automatic keys(input int k);
    key_down_pin <= 1'b1;
    key_right_pin <= 1'b1;
    repeat (k) @(posedge clk_sys);
    key_down_pin <= 1'b0;
    key_right_pin <= 1'b0;
    @(posedge clk_sys);
  endtask : keys
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    apb(1'b0, ADDR_OFFSET, 32'h0);
    `CHK("offset_rst", 8'h00, rd[7:0])
    apb(1'b0, ADDR_FAN_ON, 32'h0);
    `CHK("fan_thr_rst", 8'd30, rd[7:0])
    apb(1'b0, ADDR_OVERHEAT, 32'h0);
    `CHK("hot_thr_rst", 8'd48, rd[7:0])
    apb(1'b0, ADDR_DELAY, 32'h0);
    `CHK("delay_rst", 8'd15, rd[7:0])
    apb(1'b0, ADDR_COLD, 32'h0);
    `CHK("cold_rst", 8'hF6, rd[7:0])
    apb(1'b1, ADDR_OVERHEAT, 32'd99);
    apb(1'b0, ADDR_OVERHEAT, 32'h0);
    `CHK("hot_thr_max", 8'd65, rd[7:0])
    apb(1'b0, 8'h3C, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    apb(1'b1, ADDR_OVERHEAT, 32'd48);
    apb(1'b1, ADDR_DELAY, 32'd2);
  endtask : t_regs
  task automatic t_fan();
    apb(1'b1, ADDR_OFFSET, 32'hFD);
    settemp(8'sd27, 100);
    `CHK("fan_on_thr", 1'b1, fan_on)
    apb(1'b0, ADDR_TEMP, 32'h0);
    `CHK("work_temp", 8'd30, rd[7:0])
    settemp(8'sd23, 100);
    `CHK("fan_hyst_hold", 1'b1, fan_on)
    settemp(8'sd22, 100);
    `CHK("fan_hyst_off", 1'b0, fan_on)
    apb(1'b1, ADDR_OFFSET, 32'h0);
  endtask : t_fan
  task automatic t_hot();
    apb(1'b1, ADDR_IRQ_EN, 32'h2);
    ramp(8'sd45);
    settemp(8'sd45, 100);
    `CHK("warn_low", 1'b0, warn)
    cab_temp <= 8'sd46;
    `WAITV(warn, 1'b1, 100)
    `CHK("warn_set", 1'b1, warn)
    settemp(8'sd49, 300);
    settemp(8'sd46, 40);
    settemp(8'sd49, 450);
    `CHK("alarm_restart", 1'b0, alarm)
    `WAITV(alarm, 1'b1, 800)
    `CHK("alarm_set", 1'b1, alarm)
    `CHK("steps_forced", 1'b1, steps_off)
    `CHK("warn_replaced", 1'b0, warn)
    `CHK("irq_alarm", 1'b1, irq)
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    `CHK("irq_stat", 1'b1, rd[IRQ_ALARM])
    apb(1'b1, ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk_sys);
    `CHK("irq_masked", 1'b0, irq)
    apb(1'b1, ADDR_IRQ_EN, 32'h2);
    settemp(8'sd40, 800);
    `CHK("alarm_hyst", 1'b1, alarm)
    settemp(8'sd35, 400);
    `CHK("alarm_clr_wait", 1'b1, alarm)
    `WAITV(alarm, 1'b0, 900)
    `CHK("alarm_clr", 1'b0, alarm)
    `CHK("steps_free", 1'b0, steps_off)
    apb(1'b1, ADDR_IRQ_CLR, 32'h2);
    @(posedge clk_sys);
    `CHK("irq_cleared", 1'b0, irq)
  endtask : t_hot
  task automatic t_stop();
    ramp(8'sd62);
    settemp(8'sd62, 60);
    `CHK("stop_below", 1'b0, stop)
    cab_temp <= 8'sd63;
    `WAITV(stop, 1'b1, 100)
    `CHK("stop_set", 1'b1, stop)
    `CHK("stop_fan_off", 1'b0, fan_on)
    settemp(8'sd25, 50);
    keys(15);
    `CHK("short_press", 1'b1, stop)
    keys(60);
    `WAITV(stop, 1'b0, 50)
    `CHK("restart", 1'b0, stop)
  endtask : t_stop
  task automatic t_rise();
    ramp(8'sd36);
    settemp(8'sd36, 700);
    `CHK("rise_idle", 1'b0, stop)
    cab_temp <= 8'sd42;
    `WAITV(stop, 1'b1, 1300)
    `CHK("rise_stop", 1'b1, stop)
    `CHK("rise_fan_off", 1'b0, fan_on)
    settemp(8'sd20, 20);
    keys(60);
    `WAITV(stop, 1'b0, 50)
    `CHK("rise_restart", 1'b0, stop)
  endtask : t_rise
  task automatic t_cold();
    settemp(-8'sd11, 400);
    `CHK("cold_wait", 1'b0, alarm)
    `WAITV(alarm, 1'b1, 900)
    `CHK("cold_alarm", 1'b1, alarm)
    `CHK("cold_steps", 1'b1, steps_off)
    settemp(-8'sd9, 400);
    `CHK("cold_hold", 1'b1, alarm)
    `WAITV(alarm, 1'b0, 900)
    `CHK("cold_clr", 1'b0, alarm)
  endtask : t_cold
  task automatic t_power();
    ramp(8'sd49);
    `WAITV(alarm, 1'b1, 1300)
    `CHK("pwr_pre_alarm", 1'b1, alarm)
    settemp(8'sd40, 50);
    reset <= 1'b1;
    repeat (16) @(posedge clk_sys);
    `CHK("rst_outputs", 1'b0, steps_off)
    reset <= 1'b0;
    repeat (700) @(posedge clk_sys);
    `CHK("pwr_alarm", 1'b0, alarm)
    `CHK("pwr_steps", 1'b0, steps_off)
  endtask : t_power
  initial
  begin
    repeat (16) @(posedge clk_sys);
    `CHK("rst_fan", 1'b0, fan_on)
    reset <= 1'b0;
    t_regs();
    t_fan();
    t_hot();
    t_stop();
    t_rise();
    t_cold();
    t_power();
    wrap_up();
  end
endmodule : tb
`default_nettype wire

// ### sim/temp_sensor_model.sv
// Partner model: case sensor delivering periodic raw temperature samples
`default_nettype none
module temp_sensor_model
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic signed [7:0] cabinet_temp,
  output logic sample_valid,
  output logic signed [7:0] raw_temp
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_ff;
  // One sample every eight cycles; data inverted between samples so a stale read shows up
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cnt_ff <= 3'h0;
      sample_valid <= 1'b0;
      raw_temp <= 8'sh00;
    end
    else
    begin
      cnt_ff <= cnt_ff + 3'h1;
      sample_valid <= (cnt_ff == 3'h7);
      raw_temp <= (cnt_ff == 3'h7) ? cabinet_temp : ~cabinet_temp;
    end
  end
endmodule : temp_sensor_model
`default_nettype wire
